// ---- common/pid_pkg.sv ----
// Shared constants for the feedback, regulator and sleep supervisor block.
// Assumes a 250 MHz core clock and a 32-bit AHB-Lite register bus.
package pid_pkg;
  // ==========================================
  // Timing
  localparam int CLK_PERIOD_NS = 4;                       // Core clock period
  localparam int TICK_NS       = 1000;                    // Regulator/delay tick period
  localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS; // Cycles per tick
  // ==========================================
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL     = 8'h00; // Mode selections
  localparam logic [7:0] OFS_SETPOINT = 8'h04; // Internal setpoint
  localparam logic [7:0] OFS_A_LIMITS = 8'h08; // Value A low/high
  localparam logic [7:0] OFS_B_LIMITS = 8'h0c; // Value B low/high
  localparam logic [7:0] OFS_LEVELS   = 8'h10; // Doze threshold, wake percent
  localparam logic [7:0] OFS_DOZE_DLY = 8'h14; // Doze entry delay, ticks
  localparam logic [7:0] OFS_WAKE_DLY = 8'h18; // Wake delay, ticks
  localparam logic [7:0] OFS_GAINS    = 8'h1c; // Gain shifts of both banks
  localparam logic [7:0] OFS_STATUS   = 8'h20; // Read-only state
  // ==========================================
  // Control field positions
  localparam int F_COMB   = 0;  // [3:0] combine select 1..9
  localparam int F_ASRC   = 4;  // [5:4] value A source 1..2
  localparam int F_BSRC   = 6;  // [7:6] value B source 1..2
  localparam int F_BANK   = 8;  // [10:8] gain bank select 1..7
  localparam int F_SLEEP  = 11; // [13:11] sleep select 0..5
  localparam int F_SPSEL  = 14; // [15:14] setpoint select 1..2
  localparam int F_INV    = 16; // [16] error sign invert
  // ==========================================
  // Reset values
  localparam logic [16:0] CTRL_RST   = 17'h04651; // Value A, input one/one, set one, internal
  localparam logic [15:0] SP_RST     = 16'h0000;
  localparam logic [31:0] LIMITS_RST = 32'hffff0000; // High full scale, low zero
  localparam logic [31:0] LEVELS_RST = 32'h00000000;
  localparam logic [31:0] DLY_RST    = 32'h00000000;
  localparam logic [7:0]  GAINS_RST  = 8'h44;
  localparam logic [7:0]  ALARM_SLEEP_CODE = 8'h1c; // Alarm 28
  localparam logic [15:0] FULL_SCALE = 16'hffff;
  // ==========================================
  // Selector codes
  localparam logic [3:0] CB_A = 4'h1, CB_DIFF = 4'h2, CB_SUM = 4'h3, CB_MUL = 4'h4, CB_DIV = 4'h5;
  localparam logic [3:0] CB_MIN = 4'h6, CB_MAX = 4'h7, CB_SQDIFF = 4'h8, CB_SQSUM = 4'h9;
  localparam logic [2:0] BANK_ONE = 3'h6, BANK_TWO = 3'h7;
  localparam logic [1:0] SP_EXTERNAL = 2'h2;
  localparam logic [1:0] SRC_IN_TWO = 2'h2;
  typedef enum logic [1:0] {ST_RUN = 2'b01, ST_DOZE = 2'b10} doze_state_t;
endpackage

// ---- verilog/pid_feedback_sleep_control.sv ----
// Feedback combiner, speed regulator and sleep supervisor with AHB-Lite registers.
// Assumes all inputs synchronous to core_clk; bus is a single-slave AHB-Lite segment.
//
// Notes on behaviour
// - Regulate speed so feedback follows setpoint.
// - Invert bit negates the error sign.
// - Combine codes 1-3: A, A-B, A+B.
// - Codes 4-7: product, quotient, minimum, maximum.
// - Code 8 sqrt(A-B), code 9 sqrtA+sqrtB.
// - Value A source: input one or two.
// - Value B source selected independently.
// - Each value scaled between own limits.
// - Stop and sleep after low-frequency delay.
// - Delay counter starts below sleep level.
// - Delay counter clears above sleep level.
// - Alarm 28 shown while sleeping.
// - Wake limit is reference times percent/100.
// - Wake after feedback below limit for delay.
// - Inversion flips the wake comparison.
// - Bank codes 1-5 follow digital inputs.
// - Bank codes 6/7 force set one/two.
// - Sleep may be driven by digital input.
// - Sleep code 0 internal, 1-5 inputs.
// - Setpoint internal (1) or external (2).
//
// Chosen here: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module pid_feedback_sleep_control
  import pid_pkg::*;
(
  input  wire logic        core_clk,               // 250 MHz clock
  input  wire logic        rst,                    // Async reset, high
  input  wire logic        hsel,                   // AHB select
  input  wire logic [7:0]  haddr,                  // AHB byte address
  input  wire logic [1:0]  htrans,                 // AHB transfer type
  input  wire logic        hwrite,                 // AHB write
  input  wire logic [2:0]  hsize,                  // AHB size (word only)
  input  wire logic [31:0] hwdata,                 // AHB write data
  input  wire logic        hready,                 // AHB bus ready
  output logic             hreadyout,              // AHB slave ready
  output logic [31:0]      hrdata,                 // AHB read data
  output logic             hresp,                  // AHB response, always OKAY
  input  wire logic [15:0] analog_in_one,          // Analog input one
  input  wire logic [15:0] analog_in_two,          // Analog input two
  input  wire logic [15:0] ext_setpoint,           // External reference
  input  wire logic [15:0] output_freq,            // Present output frequency
  input  wire logic [4:0]  digital_in_one_to_five, // Digital inputs
  output logic [15:0]      speed_cmd,              // Commanded speed
  output logic             motor_stop,             // Motor stopped by sleep
  output logic             sleep_alarm,            // Alarm 28 active
  output logic             gain_bank               // 0 set one, 1 set two
);
  // ==========================================
  // Helpers
  // Integer square root, Q16 in and out when fed x<<16
  function automatic logic [15:0] isqrt(input logic [31:0] x);
    logic [15:0] r;
    logic [15:0] c;
    r = 16'h0;
    for (int i = 15; i >= 0; i--) begin
      c = r | (16'h1 << i);
      if ({16'h0, c} * {16'h0, c} <= x) r = c;
    end
    return r;
  endfunction
  // Linear map of raw between low and high onto full scale
  function automatic logic [15:0] scale(input logic [15:0] raw, input logic [15:0] lo, input logic [15:0] hi);
    logic [31:0] q;
    q = 32'h0;
    if (raw <= lo) return 16'h0;
    if (raw >= hi) return FULL_SCALE;
    q = {raw - lo, 16'h0} / {16'h0, hi - lo};
    return q[15:0];
  endfunction
  // Digital input picked by a 1..5 code
  function automatic logic pick_di(input logic [2:0] code, input logic [4:0] di);
    return (code >= 3'h1 && code <= 3'h5) ? di[code - 3'h1] : 1'b0;
  endfunction

  // ==========================================
  // Registers
  logic [16:0] ctrl_ff;       // Mode selections
  logic [15:0] setpoint_ff;   // Internal setpoint
  logic [31:0] a_limits_ff;   // Value A limits
  logic [31:0] b_limits_ff;   // Value B limits
  logic [31:0] levels_ff;     // Doze threshold, wake percent
  logic [31:0] doze_dly_ff;   // Doze entry delay
  logic [31:0] wake_dly_ff;   // Wake delay
  logic [7:0]  gains_ff;      // Gain shifts
  logic        wr_pend_ff;    // Write data phase pending
  logic        rd_pend_ff;    // Read wait state pending
  logic [7:0]  addr_ff;       // Latched address
  logic        hready_ff;     // Ready output
  logic [31:0] hrdata_ff;     // Read data output
  logic [31:0] rd_word;       // Read mux
  logic        accept;        // Address phase taken

  wire [3:0] comb_sel   = ctrl_ff[F_COMB +: 4];
  wire [1:0] a_src      = ctrl_ff[F_ASRC +: 2];
  wire [1:0] b_src      = ctrl_ff[F_BSRC +: 2];
  wire [2:0] bank_sel   = ctrl_ff[F_BANK +: 3];
  wire [2:0] sleep_sel  = ctrl_ff[F_SLEEP +: 3];
  wire [1:0] sp_sel     = ctrl_ff[F_SPSEL +: 2];
  wire       error_sign_invert = ctrl_ff[F_INV];

  assign accept = hsel && htrans[1] && hready;

  // Bus phase tracking; reads get one wait state so a write just before is seen
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wr_pend_ff <= 1'b0;
      rd_pend_ff <= 1'b0;
      addr_ff    <= 8'h0;
      hready_ff  <= 1'b1;
    end else begin
      wr_pend_ff <= accept && hwrite;
      rd_pend_ff <= accept && !hwrite;
      hready_ff  <= !(accept && !hwrite);
      if (accept) addr_ff <= haddr;
    end
  end

  // Register writes in the data phase
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl_ff     <= CTRL_RST;
      setpoint_ff <= SP_RST;
      a_limits_ff <= LIMITS_RST;
      b_limits_ff <= LIMITS_RST;
      levels_ff   <= LEVELS_RST;
      doze_dly_ff <= DLY_RST;
      wake_dly_ff <= DLY_RST;
      gains_ff    <= GAINS_RST;
    end else if (wr_pend_ff) begin
      case (addr_ff)
        OFS_CTRL:     ctrl_ff     <= hwdata[16:0];
        OFS_SETPOINT: setpoint_ff <= hwdata[15:0];
        OFS_A_LIMITS: a_limits_ff <= hwdata;
        OFS_B_LIMITS: b_limits_ff <= hwdata;
        OFS_LEVELS:   levels_ff   <= hwdata;
        OFS_DOZE_DLY: doze_dly_ff <= hwdata;
        OFS_WAKE_DLY: wake_dly_ff <= hwdata;
        OFS_GAINS:    gains_ff    <= hwdata[7:0];
        default:      ;           // Unmapped writes ignored
      endcase
    end
  end

  // ==========================================
  // Feedback path
  logic [15:0] a_scaled_ff;   // Scaled value A
  logic [15:0] b_scaled_ff;   // Scaled value B
  logic [15:0] feedback_ff;   // Combined feedback
  logic [15:0] nxt_feedback;  // Combiner result
  logic [31:0] prod;          // A times B
  logic [31:0] quot;          // A over B
  logic [16:0] root_sum;      // Sum of both roots, with carry

  // Source selection and scaling
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      a_scaled_ff <= 16'h0;
      b_scaled_ff <= 16'h0;
    end else begin
      a_scaled_ff <= scale((a_src == SRC_IN_TWO) ? analog_in_two : analog_in_one,
                           a_limits_ff[15:0], a_limits_ff[31:16]);
      b_scaled_ff <= scale((b_src == SRC_IN_TWO) ? analog_in_two : analog_in_one,
                           b_limits_ff[15:0], b_limits_ff[31:16]);
    end
  end

  // Combiner
  always_comb begin
    prod = {16'h0, a_scaled_ff} * {16'h0, b_scaled_ff};
    quot = (b_scaled_ff == 16'h0) ? 32'hffffffff : ({a_scaled_ff, 16'h0} / {16'h0, b_scaled_ff});
    // Two roots can each approach full scale, so keep the carry and saturate
    root_sum = {1'b0, isqrt({a_scaled_ff, 16'h0})} + {1'b0, isqrt({b_scaled_ff, 16'h0})};
    case (comb_sel)
      CB_DIFF:   nxt_feedback = (a_scaled_ff > b_scaled_ff) ? a_scaled_ff - b_scaled_ff : 16'h0;
      CB_SUM: begin
        nxt_feedback = ({1'b0, a_scaled_ff} + {1'b0, b_scaled_ff} > {1'b0, FULL_SCALE}) ? FULL_SCALE
                       : a_scaled_ff + b_scaled_ff;
      end
      CB_MUL:    nxt_feedback = prod[31:16];
      CB_DIV:    nxt_feedback = (quot[31:16] != 16'h0) ? FULL_SCALE : quot[15:0];
      CB_MIN:    nxt_feedback = (a_scaled_ff < b_scaled_ff) ? a_scaled_ff : b_scaled_ff;
      CB_MAX:    nxt_feedback = (a_scaled_ff > b_scaled_ff) ? a_scaled_ff : b_scaled_ff;
      CB_SQDIFF: begin
        nxt_feedback = (a_scaled_ff > b_scaled_ff) ? isqrt({a_scaled_ff - b_scaled_ff, 16'h0}) : 16'h0;
      end
      CB_SQSUM: begin
        nxt_feedback = root_sum[16] ? FULL_SCALE : root_sum[15:0];
      end
      default:   nxt_feedback = a_scaled_ff;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) feedback_ff <= 16'h0;
    else     feedback_ff <= nxt_feedback;
  end

  // ==========================================
  // Tick divider
  logic [15:0] tick_cnt_ff;  // Divider count
  logic        tick_ff;      // One-cycle tick
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tick_cnt_ff <= 16'h0;
      tick_ff     <= 1'b0;
    end else begin
      tick_ff     <= (tick_cnt_ff == 16'(TICK_CYCLES - 1));
      tick_cnt_ff <= (tick_cnt_ff == 16'(TICK_CYCLES - 1)) ? 16'h0 : tick_cnt_ff + 16'h1;
    end
  end

  // ==========================================
  // Reference, bank and wake limit
  logic [15:0] reference;    // Process reference
  logic [31:0] wake_prod;    // Reference times percent
  logic [31:0] wake_div;     // Divided by 100
  logic [15:0] wake_limit;   // Floating wake limit
  logic        gain_bank_ff; // Active bank
  logic        wake_cond;    // Wake comparison holds

  always_comb begin
    reference  = (sp_sel == SP_EXTERNAL) ? ext_setpoint : setpoint_ff;
    wake_prod  = {16'h0, reference} * {16'h0, levels_ff[31:16]};
    wake_div   = wake_prod / 32'd100;
    wake_limit = (wake_div[31:16] != 16'h0) ? FULL_SCALE : wake_div[15:0];
    wake_cond  = error_sign_invert ? (feedback_ff > wake_limit) : (feedback_ff < wake_limit);
  end

  // Gain bank choice
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) gain_bank_ff <= 1'b0;
    else if (bank_sel == BANK_TWO) gain_bank_ff <= 1'b1;
    else if (bank_sel == BANK_ONE) gain_bank_ff <= 1'b0;
    else gain_bank_ff <= pick_di(bank_sel, digital_in_one_to_five);
  end

  // ==========================================
  // Sleep supervisor
  doze_state_t state_ff;      // Run or doze
  logic [31:0] doze_cnt_ff;   // Low-frequency time
  logic [31:0] wake_cnt_ff;   // Wake condition time
  logic        alarm_ff;      // Alarm output
  wire         di_mode = (sleep_sel != 3'h0);
  wire         di_sleep = pick_di(sleep_sel, digital_in_one_to_five);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_ff    <= ST_RUN;
      doze_cnt_ff <= 32'h0;
      wake_cnt_ff <= 32'h0;
    end else if (di_mode) begin
      // Direct control from the digital input
      state_ff    <= di_sleep ? ST_DOZE : ST_RUN;
      doze_cnt_ff <= 32'h0;
      wake_cnt_ff <= 32'h0;
    end else if (tick_ff) begin
      case (state_ff)
        ST_RUN: begin
          wake_cnt_ff <= 32'h0;
          if (output_freq >= levels_ff[15:0]) doze_cnt_ff <= 32'h0;
          else if (doze_cnt_ff > doze_dly_ff) begin
            state_ff    <= ST_DOZE;
            doze_cnt_ff <= 32'h0;
          end else doze_cnt_ff <= doze_cnt_ff + 32'h1;
        end
        ST_DOZE: begin
          doze_cnt_ff <= 32'h0;
          if (!wake_cond) wake_cnt_ff <= 32'h0;
          else if (wake_cnt_ff >= wake_dly_ff) begin
            state_ff    <= ST_RUN;
            wake_cnt_ff <= 32'h0;
          end else wake_cnt_ff <= wake_cnt_ff + 32'h1;
        end
        default: state_ff <= ST_RUN;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) alarm_ff <= 1'b0;
    else     alarm_ff <= (state_ff == ST_DOZE);
  end

  // ==========================================
  // Regulator
  logic [15:0]        speed_ff; // Integrated speed
  logic signed [17:0] err;      // Setpoint minus feedback
  logic signed [17:0] step;     // Scaled correction
  logic signed [18:0] sum;      // Speed plus step
  always_comb begin
    err  = $signed({2'b00, reference}) - $signed({2'b00, feedback_ff});
    if (error_sign_invert) err = -err;
    step = err >>> (gain_bank_ff ? gains_ff[7:4] : gains_ff[3:0]);
    sum  = $signed({3'b000, speed_ff}) + 19'(step);
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) speed_ff <= 16'h0;
    else if (tick_ff) begin
      if (state_ff == ST_DOZE) speed_ff <= 16'h0;
      else if (sum < 0) speed_ff <= 16'h0;
      else if (sum > $signed({3'b000, FULL_SCALE})) speed_ff <= FULL_SCALE;
      else speed_ff <= sum[15:0];
    end
  end

  // ==========================================
  // Read mux and data
  always_comb begin
    case (addr_ff)
      OFS_CTRL:     rd_word = {15'h0, ctrl_ff};
      OFS_SETPOINT: rd_word = {16'h0, setpoint_ff};
      OFS_A_LIMITS: rd_word = a_limits_ff;
      OFS_B_LIMITS: rd_word = b_limits_ff;
      OFS_LEVELS:   rd_word = levels_ff;
      OFS_DOZE_DLY: rd_word = doze_dly_ff;
      OFS_WAKE_DLY: rd_word = wake_dly_ff;
      OFS_GAINS:    rd_word = {24'h0, gains_ff};
      OFS_STATUS: begin
        rd_word = {feedback_ff, alarm_ff ? ALARM_SLEEP_CODE : 8'h00, 5'h0, gain_bank_ff, alarm_ff,
                   state_ff == ST_DOZE};
      end
      default:      rd_word = 32'h0;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) hrdata_ff <= 32'h0;
    else if (rd_pend_ff) hrdata_ff <= rd_word;
  end

  assign hreadyout   = hready_ff;
  assign hrdata      = hrdata_ff;
  assign hresp       = 1'b0;
  assign speed_cmd   = speed_ff;
  assign motor_stop  = alarm_ff;
  assign sleep_alarm = alarm_ff;
  assign gain_bank   = gain_bank_ff;

  // ==========================================
  // Assertions
  localparam int TB = 260; // Bound covering one tick period
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_doze_entry; $rose(state_ff == ST_DOZE); endsequence
  sequence s_speed_zero; speed_ff == 16'h0; endsequence
  property p_sleep_stop;
    s_doze_entry |-> ##[1:TB] s_speed_zero;
  endproperty
  a_sleep_stop: assert property (p_sleep_stop) else $error("speed not zero in sleep");
  property p_alarm;
    (state_ff == ST_DOZE) |=> sleep_alarm && motor_stop;
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm missing in sleep");
  property p_cnt_clear;
    tick_ff && !di_mode && state_ff == ST_RUN && output_freq >= levels_ff[15:0] |=> doze_cnt_ff == 32'h0;
  endproperty
  a_cnt_clear: assert property (p_cnt_clear) else $error("doze count not cleared");
  property p_cnt_start;
    tick_ff && !di_mode && state_ff == ST_RUN && output_freq < levels_ff[15:0] && doze_cnt_ff <= doze_dly_ff
      |=> doze_cnt_ff == $past(doze_cnt_ff) + 32'h1;
  endproperty
  a_cnt_start: assert property (p_cnt_start) else $error("doze count not advancing");
  property p_bank_fixed;
    bank_sel == BANK_TWO ##1 bank_sel == BANK_TWO |-> gain_bank;
  endproperty
  a_bank_fixed: assert property (p_bank_fixed) else $error("bank two not forced");
  property p_di_sleep;
    (di_mode && di_sleep) [*3] |-> state_ff == ST_DOZE;
  endproperty
  a_di_sleep: assert property (p_di_sleep) else $error("input sleep not taken");
  property p_div_zero;
    comb_sel == CB_DIV && b_scaled_ff == 16'h0 |=> feedback_ff == FULL_SCALE;
  endproperty
  a_div_zero: assert property (p_div_zero) else $error("divide by zero not saturated");
  property p_sel_a;
    comb_sel == CB_A |=> feedback_ff == $past(a_scaled_ff);
  endproperty
  a_sel_a: assert property (p_sel_a) else $error("feedback not value A");
  property p_read_wait;
    accept && !hwrite |=> !hreadyout ##1 hreadyout;
  endproperty
  a_read_wait: assert property (p_read_wait) else $error("read wait state wrong");
endmodule // pid_feedback_sleep_control

// ---- testbench/drive_side_model.sv ----
// Far side model: the two analog sensors, the digital switches and the motor speed stage.
// Assumes the bench sets the raw levels; the speed stage reads the block's stop flag.
`timescale 1ns/1ps
module drive_side_model (
  input  wire logic        core_clk,               // Core clock
  input  wire logic        rst,                    // Async reset, high
  input  wire logic        motor_stop,             // Stop request from the block
  input  wire logic [15:0] ai_one_level,           // Raw level of sensor one
  input  wire logic [15:0] ai_two_level,           // Raw level of sensor two
  input  wire logic [4:0]  di_level,               // Switch levels
  input  wire logic [15:0] freq_level,             // Frequency while running
  output logic      [15:0] analog_in_one,          // Converted sensor one
  output logic      [15:0] analog_in_two,          // Converted sensor two
  output logic      [4:0]  digital_in_one_to_five, // Switch inputs
  output logic      [15:0] output_freq             // Frequency at the motor
);
  // ==========================
  // Converters sample the levels once a cycle
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      analog_in_one          <= 16'h0000;
      analog_in_two          <= 16'h0000;
      digital_in_one_to_five <= 5'h00;
    end else begin
      analog_in_one          <= ai_one_level;
      analog_in_two          <= ai_two_level;
      digital_in_one_to_five <= di_level;
    end
  end
  // A stopped motor drops to zero frequency at once
  assign output_freq = motor_stop ? 16'h0000 : freq_level;
endmodule // drive_side_model

// ---- testbench/pid_feedback_sleep_control_bench.sv ----
// Self-checking bench: register access over AHB-Lite, combiner table, bank and sleep tests.
// Assumes pid_pkg and the drive side model are compiled before it.
`timescale 1ns/1ps
module pid_feedback_sleep_control_bench
  import pid_pkg::*;
;
  // ==========================
  // Stimulus and observed signals
  logic        core_clk = 1'b0;  // Core clock
  logic        rst      = 1'b1;  // Async reset
  logic        hsel     = 1'b0;  // Bus select
  logic [7:0]  haddr    = 8'h00; // Bus address
  logic [1:0]  htrans   = 2'h0;  // Transfer type
  logic        hwrite   = 1'b0;  // Write flag
  logic [2:0]  hsize    = 3'h2;  // Word size
  logic [31:0] hwdata   = 32'h0; // Write data
  logic [15:0] ext_setpoint = 16'h0; // External reference
  logic [15:0] a1_lv = 16'h0, a2_lv = 16'h0, fr_lv = 16'h0; // Model levels
  logic [4:0]  di_lv = 5'h0;     // Switch levels
  logic        hreadyout, hresp, motor_stop, sleep_alarm, gain_bank; // Block outputs
  logic [31:0] hrdata, rd;       // Read data
  logic [15:0] speed_cmd, ai1, ai2, freq, s0; // Speed and link values
  logic [4:0]  din, dv;          // Switch inputs
  int          err_count = 0, total_checks = 0, cyc = 0; // Counters
  // Combiner cases: {select, A source, B source, input one, input two, feedback}
  localparam logic [55:0] TAB [19] = '{
    56'h16_4000_1000_4000, 56'h26_4000_1000_3000, 56'h36_4000_1000_5000, 56'h46_4000_1000_0400,
    56'h56_4000_1000_ffff, 56'h66_4000_1000_1000, 56'h76_4000_1000_4000, 56'h86_4000_1000_6ed9,
    56'h96_4000_1000_c000, 56'h29_4000_1000_0000, 56'h59_4000_1000_4000, 56'h89_4000_1000_0000,
    56'h56_0800_0000_ffff, 56'h3a_4000_1000_2000, 56'h16_3000_0000_8000, 56'h16_0800_0000_0000,
    56'h16_6000_0000_ffff, 56'h76_0800_3000_8000, 56'h96_ffff_ffff_ffff};
  // ==========================
  // Clock and instances
  always #(CLK_PERIOD_NS / 2) core_clk = ~core_clk;
  pid_feedback_sleep_control dut (.core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .analog_in_one(ai1), .analog_in_two(ai2),
    .ext_setpoint(ext_setpoint), .output_freq(freq), .digital_in_one_to_five(din), .speed_cmd(speed_cmd),
    .motor_stop(motor_stop), .sleep_alarm(sleep_alarm), .gain_bank(gain_bank));
  drive_side_model far (.core_clk(core_clk), .rst(rst), .motor_stop(motor_stop), .ai_one_level(a1_lv),
    .ai_two_level(a2_lv), .di_level(di_lv), .freq_level(fr_lv), .analog_in_one(ai1),
    .analog_in_two(ai2), .digital_in_one_to_five(din), .output_freq(freq));
  // ==========================
  // Tasks
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Compare one value and report a mismatch
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One single word transfer; address phase held until ready, then data phase
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= wr;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic lv(input logic [15:0] a1, a2, input logic [4:0] di, input logic [15:0] fr);
    @(posedge core_clk);
    a1_lv <= a1;
    a2_lv <= a2;
    di_lv <= di;
    fr_lv <= fr;
  endtask
  task automatic tk(input int n);
    repeat (n * TICK_CYCLES + 4) @(posedge core_clk);
  endtask
  // Control word from {select, sources}, bank, sleep select, setpoint select, invert
  function automatic logic [31:0] ctrl(input logic [7:0] s, input logic [2:0] bk, sl, input logic [1:0] sp,
                                       input logic inv);
    return {15'h0, inv, sp, sl, bk, s[1:0], s[3:2], s[7:4]};
  endfunction
  // Watchdog against a hung handshake
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      test_done();
    end
  end
  // ==========================
  // Main sequence
  initial begin : main
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    bus(0, OFS_CTRL, 0); chk(rd, {15'h0, CTRL_RST});
    bus(0, OFS_A_LIMITS, 0); chk(rd, LIMITS_RST);
    bus(1, 8'h80, 32'h1234_5678); bus(0, 8'h80, 0); chk(rd, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    for (int i = 0; i < 19; i++) begin
      if (i == 14) begin
        bus(1, OFS_A_LIMITS, 32'h5000_1000);
        bus(1, OFS_B_LIMITS, 32'h5000_1000);
      end
      lv(TAB[i][47:32], TAB[i][31:16], 5'h0, 16'h0);
      bus(1, OFS_CTRL, ctrl(TAB[i][55:48], BANK_ONE, 3'h0, 2'h1, 1'b0));
      tk(0); bus(0, OFS_STATUS, 0); chk(rd[31:16], TAB[i][15:0]);
    end
    bus(1, OFS_A_LIMITS, LIMITS_RST);
    for (int b = 1; b < 8; b++) begin
      for (int v = 0; v < 2; v++) begin
        dv = 5'h1 << (b - 1);
        if (v == 0) dv = ~dv;
        lv(16'h0, 16'h0, dv, 16'h0);
        bus(1, OFS_CTRL, ctrl(8'h16, b[2:0], 3'h0, 2'h1, 1'b0));
        tk(0); chk({31'h0, gain_bank}, (b < 6) ? v : 32'(b == 7));
        if (b < 6) begin
          bus(1, OFS_CTRL, ctrl(8'h16, BANK_ONE, b[2:0], 2'h1, 1'b0));
          tk(0); chk({30'h0, sleep_alarm, motor_stop}, v ? 32'h3 : 32'h0);
        end
      end
    end
    // Input-driven sleep outlives a switch to internal mode; release it before regulating
    lv(16'h0, 16'h0, 5'h0, 16'h0);
    bus(1, OFS_CTRL, ctrl(8'h16, BANK_ONE, 3'h1, 2'h1, 1'b0));
    tk(0);
    chk({30'h0, sleep_alarm, motor_stop}, 32'h0);
    bus(1, OFS_SETPOINT, 32'h8000);
    lv(16'h2000, 16'h0, 5'h0, 16'h0200);
    bus(1, OFS_CTRL, ctrl(8'h16, BANK_ONE, 3'h0, 2'h1, 1'b0));
    s0 = speed_cmd;
    tk(4); chk({31'h0, speed_cmd > s0}, 32'h1);
    s0 = speed_cmd;
    bus(1, OFS_CTRL, ctrl(8'h16, BANK_ONE, 3'h0, SP_EXTERNAL, 1'b0));
    tk(4); chk({31'h0, speed_cmd < s0}, 32'h1);
    s0 = speed_cmd;
    bus(1, OFS_CTRL, ctrl(8'h16, BANK_ONE, 3'h0, 2'h1, 1'b1));
    tk(2); chk({31'h0, speed_cmd < s0}, 32'h1);
    bus(1, OFS_LEVELS, 32'h0032_0100);
    bus(1, OFS_DOZE_DLY, 32'h3);
    bus(1, OFS_WAKE_DLY, 32'h3);
    bus(1, OFS_CTRL, ctrl(8'h16, BANK_ONE, 3'h0, 2'h1, 1'b0));
    lv(16'h4000, 16'h0, 5'h0, 16'h0050); tk(3);
    lv(16'h4000, 16'h0, 5'h0, 16'h0200); tk(2);
    lv(16'h4000, 16'h0, 5'h0, 16'h0050); tk(3); chk({31'h0, motor_stop}, 32'h0);
    tk(3); chk({15'h0, speed_cmd, sleep_alarm}, 32'h1);
    bus(0, OFS_STATUS, 0); chk({24'h0, rd[15:8]}, {24'h0, ALARM_SLEEP_CODE});
    lv(16'h4000, 16'h0, 5'h0, 16'h0200); tk(6); chk({31'h0, motor_stop}, 32'h1);
    lv(16'h3f00, 16'h0, 5'h0, 16'h0200); tk(1); chk({31'h0, motor_stop}, 32'h1);
    tk(4); chk({31'h0, motor_stop}, 32'h0);
    bus(1, OFS_CTRL, ctrl(8'h16, BANK_ONE, 3'h0, 2'h1, 1'b1));
    lv(16'h4000, 16'h0, 5'h0, 16'h0050); tk(6); chk({31'h0, motor_stop}, 32'h1);
    lv(16'h4000, 16'h0, 5'h0, 16'h0200); tk(6); chk({31'h0, motor_stop}, 32'h1);
    lv(16'h4100, 16'h0, 5'h0, 16'h0200); tk(5); chk({31'h0, motor_stop}, 32'h0);
    test_done();
  end
endmodule // pid_feedback_sleep_control_bench
